/* File: logic/qdp_command_unit.sv */
/*
 serial command unit of a quad 64-step wiper device: frame receiver, command
 executor, wiper registers, nonvolatile store model and response shifter.
 assumes an spi mode 0 host whose sclk is at most clk_sys/8 and that waits
 four clk_sys cycles after cs_n falls before the first sclk rise.
*/
// Overview of operation
// - restore copies the channel's stored slot into its wiper register
// - left shift doubles the channel wiper code
// - left shift of midscale or above gives full scale, never overflow
// - user store to location five writes data into first spare byte
// - eleven spare user locations, five to fifteen, eight bits each
// - each frame shifts out the whole word received in the last executed frame, unless that frame was a read
// - read memory prepares the addressed stored byte for next frame
// - read response word is command byte then eight data bits
// - no-op after a read clocks data out and returns device to idle
// - wiper readback prepares the channel's current code for next frame
// - wiper readback word is command byte then current code
// - write wiper sets the channel code directly from data
// - each wiper register holds a six-bit code, sixty-four taps
// - increment raises the channel code by one step per frame
// - store copies the channel wiper code into its nonvolatile slot
// - wipers reload from stored slots at power-on, preset strobe, restore
`timescale 1ns/1ps

`include "qdp_defines.svh"

module qdp_command_unit
	import qdp_pkg::*;
(
	input  wire logic  clk_sys,
	input  wire logic  rst_n,
	input  wire logic  spi_sclk,
	input  wire logic  spi_cs_n,
	input  wire logic  serial_command_in,
	output logic       serial_response_out,
	output logic       serial_response_oe,
	input  wire logic  preset_reload_n,
	output qdp_code_t  wiper_setting_register_ch1,
	output qdp_code_t  wiper_setting_register_ch2,
	output qdp_code_t  wiper_setting_register_ch3,
	output qdp_code_t  wiper_setting_register_ch4,
	output logic       low_power_idle,
	output logic       cmd_done
);

	function automatic qdp_code_t sat_code(input logic [7:0] v);
		sat_code = (v > `QDP_CODE_MAX) ? qdp_code_t'(`QDP_CODE_MAX) : v[`QDP_CODE_BITS-1:0];
	endfunction

	logic [3:0]  pin_s;
	logic        sclk_d_r;
	logic        cs_d_r;
	logic        preset_d_r;
	qdp_state_t  state_r;
	logic [15:0] rx_r;
	logic [15:0] tx_r;
	logic [15:0] resp_r;
	logic [4:0]  bit_cnt_r;
	logic        reload_pend_r;
	qdp_code_t   wiper_r [`QDP_CHANNELS];
	logic [7:0]  nv_store_r [`QDP_NV_DEPTH];

	qdp_sync #(
		.WIDTH   (4),
		.RST_VAL (`QDP_SYNC_RST)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.async_in ({preset_reload_n, serial_command_in, spi_cs_n, spi_sclk}),
		.sync_out (pin_s)
	);

	wire sclk_s      = pin_s[0];
	wire cs_s        = pin_s[1];
	wire cmd_in_s    = pin_s[2];
	wire preset_s    = pin_s[3];
	wire sclk_rise   = sclk_s & ~sclk_d_r;
	wire sclk_fall   = ~sclk_s & sclk_d_r;
	wire cs_fall     = ~cs_s & cs_d_r;
	wire cs_rise     = cs_s & ~cs_d_r;
	wire preset_fall = ~preset_s & preset_d_r;

	wire        exec  = (state_r == QDP_ST_EXEC);
	wire [3:0]  instr = rx_r[`QDP_INSTR_MSB:`QDP_INSTR_LSB];
	wire [3:0]  addr  = rx_r[`QDP_ADDR_MSB:`QDP_ADDR_LSB];
	wire [7:0]  data  = rx_r[`QDP_DATA_MSB:`QDP_DATA_LSB];
	wire        is_ch = (addr <= `QDP_CH_LAST);
	wire [1:0]  ch    = addr[1:0];
	wire        reload_now = reload_pend_r | preset_fall;

	// edge history of the synchronised pins
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sclk_d_r   <= 1'b0;
			cs_d_r     <= 1'b1;
			preset_d_r <= 1'b1;
		end else begin
			sclk_d_r   <= sclk_s;
			cs_d_r     <= cs_s;
			preset_d_r <= preset_s;
		end
	end

	// frame sequencing
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r <= QDP_ST_IDLE;
		end else begin
			unique case (state_r)
				QDP_ST_IDLE: begin
					if (cs_fall) begin
						state_r <= QDP_ST_FRAME;
					end
				end
				QDP_ST_FRAME: begin
					if (cs_rise) begin
						state_r <= (bit_cnt_r == `QDP_FRAME_BITS) ? QDP_ST_EXEC : QDP_ST_IDLE;
					end
				end
				QDP_ST_EXEC: begin
					state_r <= QDP_ST_IDLE;
				end
				default: begin
					state_r <= QDP_ST_IDLE;
				end
			endcase
		end
	end

	// receive shifter, msb first on sclk rise
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rx_r      <= `QDP_RX_RESET;
			bit_cnt_r <= `QDP_CNT_RESET;
		end else if (cs_fall) begin
			bit_cnt_r <= `QDP_CNT_RESET;
		end else if (state_r == QDP_ST_FRAME && sclk_rise) begin
			rx_r <= {rx_r[14:0], cmd_in_s};
			if (bit_cnt_r != `QDP_CNT_MAX) begin
				bit_cnt_r <= bit_cnt_r + 5'h01;
			end
		end
	end

	// transmit shifter: loaded at frame start, advanced on sclk fall
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tx_r <= `QDP_RESP_RESET;
		end else if (cs_fall) begin
			tx_r <= resp_r;
		end else if (state_r == QDP_ST_FRAME && sclk_fall) begin
			tx_r <= {tx_r[14:0], 1'b0};
		end
	end

	assign serial_response_out = tx_r[15];
	assign serial_response_oe  = (state_r == QDP_ST_FRAME);

	// word offered in the next frame
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			resp_r <= `QDP_RESP_RESET;
		end else if (exec) begin
			if (instr == `QDP_I_READ_MEM) begin
				resp_r <= {rx_r[15:8], nv_store_r[addr]};
			end else if (instr == `QDP_I_READ_WIPER) begin
				resp_r <= {rx_r[15:8], 2'b00, is_ch ? wiper_r[ch] : 6'h00};
			end else begin
				resp_r <= rx_r;
			end
		end
	end

	// power-on reload request, consumed one cycle after reset release
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reload_pend_r <= 1'b1;
		end else begin
			reload_pend_r <= 1'b0;
		end
	end

	// wiper registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < `QDP_CHANNELS; i++) begin
				wiper_r[i] <= `QDP_WIPER_RESET;
			end
		end else if (reload_now) begin
			for (int i = 0; i < `QDP_CHANNELS; i++) begin
				wiper_r[i] <= nv_store_r[i][`QDP_CODE_BITS-1:0];
			end
		end else if (exec && is_ch) begin
			case (instr)
				`QDP_I_RESTORE: wiper_r[ch] <= nv_store_r[addr][`QDP_CODE_BITS-1:0];
				`QDP_I_WRITE:   wiper_r[ch] <= sat_code(data);
				`QDP_I_SHL:     wiper_r[ch] <= sat_code({1'b0, wiper_r[ch], 1'b0});
				`QDP_I_INC:     wiper_r[ch] <= sat_code({2'b00, wiper_r[ch]} + `QDP_ONE_STEP);
				default: ;
			endcase
		end
	end

	// nonvolatile store: channel slots 0-3, spare user bytes 5-15
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < `QDP_NV_DEPTH; i++) begin
				nv_store_r[i] <= `QDP_NV_RESET;
			end
		end else if (exec) begin
			if (instr == `QDP_I_STORE && is_ch) begin
				nv_store_r[addr] <= {2'b00, wiper_r[ch]};
			end else if (instr == `QDP_I_USTORE && addr >= `QDP_USER_FIRST) begin
				nv_store_r[addr] <= data;
			end
		end
	end

	// idle power state and completion strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			low_power_idle <= 1'b1;
			cmd_done       <= 1'b0;
		end else begin
			cmd_done <= exec;
			if (exec) begin
				case (instr)
					`QDP_I_NOP:        low_power_idle <= 1'b1;
					`QDP_I_RESTORE,
					`QDP_I_READ_MEM,
					`QDP_I_READ_WIPER: low_power_idle <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	assign wiper_setting_register_ch1 = wiper_r[0];
	assign wiper_setting_register_ch2 = wiper_r[1];
	assign wiper_setting_register_ch3 = wiper_r[2];
	assign wiper_setting_register_ch4 = wiper_r[3];

	// checking
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	qdp_code_t  wiper_sel;
	logic [7:0] nv_sel;
	logic       upd_ok;
	assign wiper_sel = wiper_r[ch];
	assign nv_sel    = nv_store_r[addr];
	assign upd_ok    = exec && is_ch && !reload_now;

	restore_copy_a: assert property (
		upd_ok && instr == `QDP_I_RESTORE
		|=> wiper_r[$past(ch)] == $past(nv_sel[`QDP_CODE_BITS-1:0]))
		else $error("restore did not copy stored slot");
	shl_double_a: assert property (
		upd_ok && instr == `QDP_I_SHL && wiper_sel < `QDP_MIDSCALE
		|=> wiper_r[$past(ch)] == ($past(wiper_sel) << 1))
		else $error("left shift did not double");
	shl_saturate_a: assert property (
		upd_ok && instr == `QDP_I_SHL && wiper_sel >= `QDP_MIDSCALE
		|=> wiper_r[$past(ch)] == `QDP_FULL_SCALE)
		else $error("left shift did not saturate");
	user_store_a: assert property (
		exec && instr == `QDP_I_USTORE && addr >= `QDP_USER_FIRST
		|=> nv_store_r[$past(addr)] == $past(data))
		else $error("user byte not written");
	echo_prev_a: assert property (
		exec && instr != `QDP_I_READ_MEM && instr != `QDP_I_READ_WIPER
		|=> resp_r == $past(rx_r))
		else $error("previous word not offered");
	read_mem_a: assert property (
		exec && instr == `QDP_I_READ_MEM |=> resp_r == {$past(rx_r[15:8]), $past(nv_sel)})
		else $error("memory readback word wrong");
	read_wiper_a: assert property (
		exec && is_ch && instr == `QDP_I_READ_WIPER
		|=> resp_r == {$past(rx_r[15:8]), 2'b00, $past(wiper_sel)})
		else $error("wiper readback word wrong");
	write_wiper_a: assert property (
		upd_ok && instr == `QDP_I_WRITE && data <= `QDP_CODE_MAX
		|=> wiper_r[$past(ch)] == $past(data[`QDP_CODE_BITS-1:0]))
		else $error("write wiper failed");
	inc_step_a: assert property (
		upd_ok && instr == `QDP_I_INC && wiper_sel != `QDP_FULL_SCALE
		|=> wiper_r[$past(ch)] == $past(wiper_sel) + qdp_code_t'(`QDP_ONE_STEP))
		else $error("increment not one step");
	store_slot_a: assert property (
		exec && is_ch && instr == `QDP_I_STORE |=> nv_store_r[$past(addr)] == {2'b00, $past(wiper_sel)})
		else $error("store slot wrong");
	preset_load_a: assert property (
		preset_fall |=> wiper_r[0] == $past(nv_store_r[0][`QDP_CODE_BITS-1:0]))
		else $error("preset reload failed");
	short_frame_a: assert property (
		state_r == QDP_ST_FRAME && cs_rise && bit_cnt_r != `QDP_FRAME_BITS
		|=> state_r == QDP_ST_IDLE ##1 !cmd_done)
		else $error("short frame executed");
	nop_idle_a: assert property (
		exec && instr == `QDP_I_NOP |=> low_power_idle && cmd_done)
		else $error("no-op did not return to idle");

	read_mem_c:    cover property (exec && instr == `QDP_I_READ_MEM);
	shl_sat_c:     cover property (upd_ok && instr == `QDP_I_SHL && wiper_sel == `QDP_MIDSCALE);
	short_frame_c: cover property (state_r == QDP_ST_FRAME && cs_rise && bit_cnt_r != `QDP_FRAME_BITS);
	preset_c:      cover property (preset_fall);

endmodule

/* File: pkg/qdp_defines.svh */
/*
 constants of the quad wiper serial command unit: frame layout, instruction codes,
 sizes and reset values. assumes inclusion by bare name from the design files.
*/
`ifndef QDP_DEFINES_SVH
`define QDP_DEFINES_SVH

`define QDP_FRAME_BITS   5'h10
`define QDP_CNT_MAX      5'h1F
`define QDP_INSTR_MSB    15
`define QDP_INSTR_LSB    12
`define QDP_ADDR_MSB     11
`define QDP_ADDR_LSB     8
`define QDP_DATA_MSB     7
`define QDP_DATA_LSB     0
`define QDP_CODE_BITS    6
`define QDP_CHANNELS     4
`define QDP_NV_DEPTH     16
`define QDP_CH_LAST      4'h3
`define QDP_USER_FIRST   4'h5
`define QDP_CODE_MAX     8'h3F
`define QDP_ONE_STEP     8'h01
`define QDP_WIPER_RESET  6'h20
`define QDP_NV_RESET     8'h20
`define QDP_RESP_RESET   16'h0000
`define QDP_RX_RESET     16'h0000
`define QDP_CNT_RESET    5'h00
`define QDP_MIDSCALE     6'h20
`define QDP_FULL_SCALE   6'h3F
`define QDP_SYNC_RST     4'hA

`define QDP_I_NOP        4'h0
`define QDP_I_RESTORE    4'h1
`define QDP_I_STORE      4'h2
`define QDP_I_USTORE     4'h3
`define QDP_I_READ_MEM   4'h9
`define QDP_I_READ_WIPER 4'hA
`define QDP_I_WRITE      4'hB
`define QDP_I_SHL        4'hC
`define QDP_I_INC        4'hE

`endif

/* File: pkg/qdp_pkg.sv */
/*
 types shared by the quad wiper serial command unit.
 assumes nothing of its surroundings.
*/
package qdp_pkg;

	typedef enum logic [2:0] {
		QDP_ST_IDLE  = 3'b001,
		QDP_ST_FRAME = 3'b010,
		QDP_ST_EXEC  = 3'b100
	} qdp_state_t;

	typedef logic [5:0] qdp_code_t;

endpackage

/* File: logic/qdp_sync.sv */
/*
 two flip-flop synchroniser for a bundle of pin inputs.
 assumes the pins are asynchronous to clk_sys; only sync_out may be read.
*/
`timescale 1ns/1ps

module qdp_sync #(
	parameter int               WIDTH   = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_r   <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

/* File: verif/qdp_spi_host.sv */
/*
 spi mode 0 host model for the wiper command unit: sends 16-bit frames msb first.
 assumes clk_sys is the device clock; all pins change on its falling edge.
*/
`timescale 1ns/1ps

module qdp_spi_host (
	input  wire logic clk_sys,
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      serial_command_in,
	input  wire logic serial_response_out
);
	initial begin
		spi_sclk          = 1'b0;
		spi_cs_n          = 1'b1;
		serial_command_in = 1'b1;
	end

	task automatic gap(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// nbits below 16 makes a refused frame; half sets the sclk phase length in clk_sys cycles
	task automatic xfer(input logic [15:0] w, input int nbits, input int half,
			output logic [15:0] rx);
		rx       = 16'h0000;
		spi_cs_n = 1'b0;
		gap(4);
		for (int i = 0; i < nbits; i++) begin
			serial_command_in = w[15 - i];
			gap(half);
			spi_sclk = 1'b1;
			rx       = {rx[14:0], serial_response_out};
			gap(half);
			spi_sclk = 1'b0;
		end
		gap(4);
		spi_cs_n          = 1'b1;
		serial_command_in = ~serial_command_in;
		gap(12);
	endtask
endmodule

/* File: verif/quad_digipot_serial_command_unit_tb.sv */
/*
 self-checking bench of the wiper command unit: a row table of frames, then hand cases.
 assumes the spi host model and the design package are compiled first.
*/
`timescale 1ns/1ps

`define QDP_CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
	$display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module quad_digipot_serial_command_unit_tb
	import qdp_pkg::*;
;
	typedef struct {
		logic [15:0] cmd;
		logic [15:0] resp;
		qdp_code_t   w1;
		logic        lpi;
	} qdp_row_t;

	logic        clk_sys;
	logic        rst_n;
	logic        preset_reload_n;
	logic        spi_sclk;
	logic        spi_cs_n;
	logic        cmd_in;
	logic        resp_out;
	logic        resp_oe;
	logic        resp_line;
	logic        lpi;
	logic        cmd_done;
	qdp_code_t   w1;
	qdp_code_t   w2;
	qdp_code_t   w3;
	qdp_code_t   w4;
	logic [15:0] rx;
	int          err_total;
	int          n_tests;
	int          n_done;

	qdp_row_t rows [17] = '{
		'{16'hB010, 16'h0000, 6'h10, 1'b1},
		'{16'hE000, 16'hB010, 6'h11, 1'b1},
		'{16'h2000, 16'hE000, 6'h11, 1'b1},
		'{16'hB020, 16'h2000, 6'h20, 1'b1},
		'{16'h1000, 16'hB020, 6'h11, 1'b0},
		'{16'h0000, 16'h1000, 6'h11, 1'b1},
		'{16'hC000, 16'h0000, 6'h22, 1'b1},
		'{16'h35AA, 16'hC000, 6'h22, 1'b1},
		'{16'h3655, 16'h35AA, 6'h22, 1'b1},
		'{16'h9500, 16'h3655, 6'h22, 1'b0},
		'{16'h0000, 16'h95AA, 6'h22, 1'b1},
		'{16'hB020, 16'h0000, 6'h20, 1'b1},
		'{16'hC000, 16'hB020, 6'h3F, 1'b1},
		'{16'hA000, 16'hC000, 6'h3F, 1'b0},
		'{16'h0000, 16'hA03F, 6'h3F, 1'b1},
		'{16'h9F00, 16'h0000, 6'h3F, 1'b0},
		'{16'h0000, 16'h9F20, 6'h3F, 1'b1}
	};

	qdp_command_unit dut_u (
		.clk_sys                   (clk_sys),
		.rst_n                     (rst_n),
		.spi_sclk                  (spi_sclk),
		.spi_cs_n                  (spi_cs_n),
		.serial_command_in         (cmd_in),
		.serial_response_out       (resp_out),
		.serial_response_oe        (resp_oe),
		.preset_reload_n           (preset_reload_n),
		.wiper_setting_register_ch1(w1),
		.wiper_setting_register_ch2(w2),
		.wiper_setting_register_ch3(w3),
		.wiper_setting_register_ch4(w4),
		.low_power_idle            (lpi),
		.cmd_done                  (cmd_done)
	);

	qdp_spi_host host_u (
		.clk_sys            (clk_sys),
		.spi_sclk           (spi_sclk),
		.spi_cs_n           (spi_cs_n),
		.serial_command_in  (cmd_in),
		.serial_response_out(resp_line)
	);

	// an undriven response line reads as the inverse of the last bit
	assign resp_line = resp_oe ? resp_out : ~resp_out;

	always @(negedge clk_sys) begin
		if (cmd_done === 1'b1) begin
			n_done++;
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#1_000_000;
		err_total++;
		report_and_stop();
	end

	initial begin
		err_total       = 0;
		n_tests         = 0;
		n_done          = 0;
		rst_n           = 1'b0;
		preset_reload_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		for (int i = 0; i < 17; i++) begin
			host_u.xfer(rows[i].cmd, 16, 4, rx);
			`QDP_CHK("response", rows[i].resp, rx)
			`QDP_CHK("wiper1", rows[i].w1, w1)
			`QDP_CHK("idle", rows[i].lpi, lpi)
			`QDP_CHK("oe", 1'b0, resp_oe)
		end
		`QDP_CHK("done", 17, n_done)
		// a fifteen-bit frame must be dropped whole
		host_u.xfer(16'hB005, 15, 4, rx);
		`QDP_CHK("wiper1", 6'h3F, w1)
		`QDP_CHK("done", 17, n_done)
		host_u.xfer(16'hB007, 16, 4, rx);
		`QDP_CHK("response", 16'h0000, rx)
		`QDP_CHK("wiper1", 6'h07, w1)
		// preset strobe reloads every wiper from its stored slot
		preset_reload_n = 1'b0;
		@(negedge clk_sys);
		preset_reload_n = 1'b1;
		repeat (6) @(negedge clk_sys);
		`QDP_CHK("wiper1", 6'h11, w1)
		`QDP_CHK("wiper2", 6'h20, w2)
		`QDP_CHK("wiper3", 6'h20, w3)
		`QDP_CHK("wiper4", 6'h20, w4)
		// slow host
		host_u.xfer(16'hE000, 16, 10, rx);
		`QDP_CHK("response", 16'hB007, rx)
		`QDP_CHK("wiper1", 6'h12, w1)
		// write data above full scale on the fourth channel saturates
		host_u.xfer(16'hB3FF, 16, 4, rx);
		`QDP_CHK("response", 16'hE000, rx)
		`QDP_CHK("wiper4", 6'h3F, w4)
		`QDP_CHK("wiper1", 6'h12, w1)
		// second reset acts as power-on
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		`QDP_CHK("wiper1", 6'h20, w1)
		`QDP_CHK("wiper4", 6'h20, w4)
		host_u.xfer(16'h0000, 16, 4, rx);
		`QDP_CHK("response", 16'h0000, rx)
		`QDP_CHK("done", 21, n_done)
		report_and_stop();
	end
endmodule
